// File: design/disc_apb_slave.sv
/*
  APB slave front end: decodes the three registers, answers with no wait
  states and flags unmapped addresses with pslverr. Assumes an APB master.
*/
`timescale 1ns/1ps
`default_nettype none
module disc_apb_slave
  import disc_pkg::*;
(
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [7:0]  reg_q,
  input  wire logic [7:0]  thr_q,
  input  wire logic [7:0]  stat_q,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             wr_reg,
  output logic             wr_thr
);

  logic hit;

  // Decode is purely combinational; every access completes in one access cycle.
  always_comb begin
    hit    = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      DISC_OFF_REGULATOR: prdata = {24'h000000, reg_q};
      DISC_OFF_THROTTLE:  prdata = {24'h000000, thr_q};
      DISC_OFF_STATUS:    prdata = {24'h000000, stat_q};
      default:            hit    = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr_reg  = psel && penable && pwrite && (paddr == DISC_OFF_REGULATOR);
  assign wr_thr  = psel && penable && pwrite && (paddr == DISC_OFF_THROTTLE);

endmodule // disc_apb_slave
`default_nettype wire

// File: design/disc_power_control.sv
/*
  Doze, idle and sleep control: two control registers and a status word over
  APB, the CPU clock gate, and the run/idle/sleep state. Assumes the core,
  interrupt logic and debug unit give one-cycle event pulses on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
//Behaviour
// - Low-power regulator bit selects low-current, slow-wake regulator state in Sleep.
// - Reserved regulator bit zero always reads one; software writes one.
// - Unimplemented bits read zero and ignore writes.
// - Idle select makes sleep stop only CPU clock; else full Sleep.
// - Throttle enable runs CPU at ratio; clear runs every cycle.
// - Throttle-off-on-INTERRUPT_SERVICE_ROUTINE clears throttle enable at interrupt entry.
// - Throttle-on-return sets throttle enable on return from interrupt.
// - Ratio code 000 gives 1:2, doubling up to 111 giving 1:256.
// - Debug entry forces full speed without changing stored throttle enable.
// - Idle select clears only on power-on/brown-out; others clear on any reset.
// - Any enabled interrupt ends Idle, idle select unchanged.
// - Watchdog timeout in Idle wakes without reset, no throttle recovery.
module disc_power_control
  import disc_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         por_reset,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  input  wire disc_events_s events,
  output logic              cpu_clock_enable,
  output logic              peripheral_clock_enable,
  output logic              regulator_low_power,
  output logic              watchdog_reset_block
);

  logic [7:0]  reg_q;
  logic [7:0]  next_reg;
  logic [7:0]  thr_q;
  logic [7:0]  next_thr;
  logic        idle_sel;
  logic        next_idle_sel;
  disc_state_e state;
  disc_state_e next_state;
  logic        wr_reg;
  logic        wr_thr;
  logic        gate_en;
  logic        debug_q;
  logic        next_debug;
  logic [7:0]  thr_view;
  logic [7:0]  stat_q;
  logic        in_debug;

  disc_apb_slave u_apb (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .reg_q   (reg_q),
    .thr_q   (thr_view),
    .stat_q  (stat_q),
    .pready  (pready),
    .pslverr (pslverr),
    .prdata  (prdata),
    .wr_reg  (wr_reg),
    .wr_thr  (wr_thr)
  );

  // Regulator register: only the mode bit is writable, reserved bit pinned to one.
  always_comb begin
    next_reg = reg_q;
    if (wr_reg && pstrb[0]) begin
      next_reg = (pwdata[7:0] & DISC_REG_MASK) | DISC_REG_RESET;
    end
  end

  // Throttle register: software writes, then hardware interrupt entry and return.
  // Hardware events follow the write so that a coincident interrupt is not lost.
  always_comb begin
    next_thr      = thr_q;
    next_idle_sel = idle_sel;
    if (wr_thr && pstrb[0]) begin
      next_thr      = pwdata[7:0] & DISC_THR_MASK & 8'h7f;
      next_idle_sel = pwdata[DISC_THR_IDLE_BIT];
    end
    if (events.isr_entry && next_thr[DISC_THR_ISR_BIT]) begin
      next_thr[DISC_THR_ENABLE_BIT] = 1'b0;
    end
    if (events.return_from_interrupt && next_thr[DISC_THR_RETURN_BIT]) begin
      next_thr[DISC_THR_ENABLE_BIT] = 1'b1;
    end
  end

  // Any reset clears the throttle fields and the regulator mode bit.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_q <= DISC_REG_RESET;
      thr_q <= DISC_THR_RESET;
    end else begin
      reg_q <= next_reg;
      thr_q <= next_thr;
    end
  end

  // Idle select survives ordinary resets; only power-on or brown-out clears it.
  always_ff @(posedge mclk or posedge por_reset) begin
    if (por_reset) begin
      idle_sel <= 1'b0;
    end else begin
      idle_sel <= next_idle_sel;
    end
  end

  assign thr_view = {idle_sel, thr_q[6:0]};

  // Run/idle/sleep state; the sleep instruction picks Idle or Sleep.
  always_comb begin
    next_state = state;
    unique case (state)
      DISC_RUN: begin
        if (events.sleep_exec) begin
          next_state = idle_sel ? DISC_IDLE : DISC_SLEEP;
        end
      end
      DISC_IDLE: begin
        if (events.wake_interrupt || events.watchdog_timeout) begin
          next_state = DISC_RUN;
        end
      end
      DISC_SLEEP: begin
        if (events.wake_interrupt || events.watchdog_timeout) begin
          next_state = DISC_RUN;
        end
      end
      default: next_state = DISC_RUN;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= DISC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Debug entry latches an override; the stored enable bit is left alone.
  always_comb begin
    next_debug = debug_q | events.in_circuit_debug;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      debug_q <= 1'b0;
    end else begin
      debug_q <= next_debug;
    end
  end

  assign in_debug = debug_q | events.in_circuit_debug;

  disc_throttle_gate u_gate (
    .mclk       (mclk),
    .reset      (reset),
    .active     (thr_q[DISC_THR_ENABLE_BIT] && !in_debug),
    .ratio      (thr_q[DISC_THR_RATIO_LSB +: DISC_THR_RATIO_W]),
    .cpu_enable (gate_en)
  );

  // CPU clock stops in Idle and Sleep; peripherals stop only in Sleep.
  assign cpu_clock_enable        = gate_en && (state == DISC_RUN);
  assign peripheral_clock_enable = (state != DISC_SLEEP);
  // The regulator low-current state applies only while sleeping.
  assign regulator_low_power     = reg_q[DISC_REG_LOW_POWER_BIT] && (state == DISC_SLEEP);
  // Watchdog resets are blocked in Idle so the timeout wakes instead.
  assign watchdog_reset_block    = (state == DISC_IDLE);
  assign stat_q = {5'h00, in_debug, state};

  property p_reserved_one;
    @(posedge mclk) disable iff (reset) reg_q[DISC_REG_RESERVED_BIT] && reg_q[7:2] == 6'h00;
  endproperty
  a_reserved_one: assert property (p_reserved_one) else $error("regulator reserved bit lost");

  property p_unimpl_zero;
    @(posedge mclk) disable iff (reset)
      (psel && penable && !pwrite && paddr == DISC_OFF_THROTTLE)
      |-> prdata[31:8] == 24'h000000 && !prdata[3] && !thr_q[3];
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  property p_idle_entry;
    @(posedge mclk) disable iff (reset)
      (state == DISC_RUN && events.sleep_exec)
      |=> state == ($past(idle_sel) ? DISC_IDLE : DISC_SLEEP);
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("wrong low power state");

  // Full Sleep must stop the peripherals as well as the CPU.
  property p_sleep_stops_all;
    @(posedge mclk) disable iff (reset)
      (state == DISC_RUN && events.sleep_exec && !idle_sel)
      |=> !peripheral_clock_enable && !cpu_clock_enable;
  endproperty
  a_sleep_stops_all: assert property (p_sleep_stops_all) else $error("sleep left a clock");

  property p_isr_clear;
    @(posedge mclk) disable iff (reset)
      (events.isr_entry && thr_q[DISC_THR_ISR_BIT] && !wr_thr && !events.return_from_interrupt)
      |=> !thr_q[DISC_THR_ENABLE_BIT];
  endproperty
  a_isr_clear: assert property (p_isr_clear) else $error("enable kept on isr entry");

  property p_return_set;
    @(posedge mclk) disable iff (reset)
      (events.return_from_interrupt && thr_q[DISC_THR_RETURN_BIT] && !wr_thr)
      |=> thr_q[DISC_THR_ENABLE_BIT];
  endproperty
  a_return_set: assert property (p_return_set) else $error("enable not set on return");

  property p_debug_full;
    @(posedge mclk) disable iff (reset)
      (in_debug && state == DISC_RUN) |-> cpu_clock_enable;
  endproperty
  a_debug_full: assert property (p_debug_full) else $error("throttled in debug");

  // Debug entry overrides the speed but must leave the stored enable bit alone.
  property p_debug_keeps_enable;
    @(posedge mclk) disable iff (reset)
      (events.in_circuit_debug && !wr_thr && !events.isr_entry && !events.return_from_interrupt)
      |=> $stable(thr_q[DISC_THR_ENABLE_BIT]);
  endproperty
  a_debug_keeps_enable: assert property (p_debug_keeps_enable) else $error("debug changed enable");

  property p_idle_wake;
    @(posedge mclk) disable iff (reset)
      (state == DISC_IDLE && (events.wake_interrupt || events.watchdog_timeout))
      |=> state == DISC_RUN && watchdog_reset_block == 1'b0;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle not left");

  property p_wdt_no_recover;
    @(posedge mclk) disable iff (reset)
      (state == DISC_IDLE && events.watchdog_timeout && !events.isr_entry && !wr_thr &&
       !events.return_from_interrupt)
      |=> $stable(thr_q[DISC_THR_ENABLE_BIT]);
  endproperty
  a_wdt_no_recover: assert property (p_wdt_no_recover) else $error("watchdog changed enable");

  property p_regulator;
    @(posedge mclk) disable iff (reset)
      regulator_low_power |-> state == DISC_SLEEP && reg_q[DISC_REG_LOW_POWER_BIT];
  endproperty
  a_regulator: assert property (p_regulator) else $error("regulator mode wrong");

  // Entering full Sleep with the mode bit set must select the low-current state.
  property p_regulator_entry;
    @(posedge mclk) disable iff (reset)
      (state == DISC_RUN && events.sleep_exec && !idle_sel && reg_q[DISC_REG_LOW_POWER_BIT] && !wr_reg)
      |=> regulator_low_power;
  endproperty
  a_regulator_entry: assert property (p_regulator_entry) else $error("low current not entered");

endmodule // disc_power_control
`default_nettype wire

// File: design/disc_throttle_gate.sv
/*
  Throttle gate: emits one CPU cycle enable per ratio-count of peripheral
  cycles. Assumes one clock and that each clock is one peripheral cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module disc_throttle_gate
  import disc_pkg::*;
#(
  parameter int RATIO_W = DISC_THR_RATIO_W
) (
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic               active,
  input  wire logic [RATIO_W-1:0] ratio,
  output logic                    cpu_enable
);

  initial begin
    if (RATIO_W != DISC_THR_RATIO_W) $error("disc_throttle_gate: ratio width unsupported");
  end

  logic [7:0]         count;
  logic [7:0]         next_count;
  logic [RATIO_W-1:0] ratio_q;
  logic               active_q;
  logic [7:0]         last;
  logic               restart;
  logic [7:0]         phase;

  // Period is 2 shifted by the ratio code; the shift amount is widened so that
  // code 111 still reaches 256 instead of wrapping to zero.
  // A change of enable or ratio starts a fresh period in that very cycle, so a
  // stale count from the old rate never decides the first gate of the new one.
  always_comb begin
    last    = 8'((9'h001 << ({1'b0, ratio} + 4'h1)) - 9'h001);
    restart = (active != active_q) || (ratio != ratio_q);
    phase   = restart ? 8'h00 : count;
    if (!active || phase == last) begin
      next_count = 8'h00;
    end else begin
      next_count = phase + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count    <= 8'h00;
      ratio_q  <= '0;
      active_q <= 1'b0;
    end else begin
      count    <= next_count;
      ratio_q  <= ratio;
      active_q <= active;
    end
  end

  // Full speed when inactive; else one cycle at count zero of each period.
  assign cpu_enable = !active || (phase == 8'h00);

  property p_one_per_period;
    @(posedge mclk) disable iff (reset)
      (active && ratio == '0 && cpu_enable) ##1 (active && ratio == '0) |-> !cpu_enable;
  endproperty
  a_one_per_period: assert property (p_one_per_period) else $error("two enables at 1:2");

  property p_full_speed;
    @(posedge mclk) disable iff (reset) !active |-> cpu_enable;
  endproperty
  a_full_speed: assert property (p_full_speed) else $error("gated while not throttling");

endmodule // disc_throttle_gate
`default_nettype wire

// File: include/disc_pkg.sv
/*
  Package for the doze, idle and sleep control block: register offsets, field
  positions, reset values, the throttle ratio width and the controller states.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
package disc_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] DISC_OFF_REGULATOR = 8'h00;
  localparam logic [7:0] DISC_OFF_THROTTLE  = 8'h04;
  localparam logic [7:0] DISC_OFF_STATUS    = 8'h08;

  // Regulator control fields.
  localparam int DISC_REG_RESERVED_BIT = 0;
  localparam int DISC_REG_LOW_POWER_BIT = 1;
  localparam logic [7:0] DISC_REG_RESET = 8'h01;

  // Throttle and idle control fields.
  localparam int DISC_THR_RATIO_LSB  = 0;
  localparam int DISC_THR_RATIO_W    = 3;
  localparam int DISC_THR_RETURN_BIT = 4;
  localparam int DISC_THR_ISR_BIT    = 5;
  localparam int DISC_THR_ENABLE_BIT = 6;
  localparam int DISC_THR_IDLE_BIT   = 7;
  localparam logic [7:0] DISC_THR_RESET = 8'h00;
  localparam logic [7:0] DISC_THR_MASK  = 8'hf7;
  localparam logic [7:0] DISC_REG_MASK  = 8'h03;

  // Longest throttle period in peripheral cycles (ratio 1:256).
  localparam int DISC_MAX_PERIOD = 256;

  // Power controller states.
  typedef enum logic [1:0] {
    DISC_RUN,
    DISC_IDLE,
    DISC_SLEEP
  } disc_state_e;

  // Events observed from the core, interrupt logic and debug unit.
  typedef struct packed {
    logic sleep_exec;
    logic isr_entry;
    logic return_from_interrupt;
    logic wake_interrupt;
    logic watchdog_timeout;
    logic in_circuit_debug;
  } disc_events_s;

endpackage

// File: sim/disc_core_model.sv
/*
  Core, interrupt and debug model: turns bench commands into one-cycle event
  pulses and counts the CPU cycles that the gate lets through.
  Assumes the block samples its events on the rising edge of mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module disc_core_model
  import disc_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire disc_events_s fire,
  input  wire logic         cpu_clock_enable,
  output var disc_events_s  events,
  output logic [15:0]       cpu_cycles
);
  // Events leave a register so each pulse holds for exactly one whole cycle.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      events     <= '0;
      cpu_cycles <= 16'h0000;
    end else begin
      events <= fire;
      if (cpu_clock_enable) begin
        cpu_cycles <= cpu_cycles + 16'h0001;
      end
    end
  end
endmodule // disc_core_model
`default_nettype wire

// File: sim/disc_power_control_test.sv
/*
  Self-checking bench for the power control block: APB register tasks,
  event pulses through the core model and CPU cycle counting.
  Assumes the block runs on one clock; the APB task waits out any wait states.
*/
`timescale 1ns/1ps
`default_nettype none
module disc_power_control_test;
  import disc_pkg::*;
  localparam disc_events_s EV_SLEEP = 6'b100000;
  localparam disc_events_s EV_ISR   = 6'b010000;
  localparam disc_events_s EV_RET   = 6'b001000;
  localparam disc_events_s EV_WAKE  = 6'b000100;
  localparam disc_events_s EV_WDT   = 6'b000010;
  localparam disc_events_s EV_DBG   = 6'b000001;
  logic mclk = 1'b0, reset = 1'b1, por_reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'hf;
  disc_events_s fire = '0, events;
  logic cpu_en, per_en, reg_lp, wdt_blk, e;
  logic [15:0] cpu_cycles, k;
  int failures = 0, samples_checked = 0, cycle_count = 0;

  disc_power_control DUT (.mclk(mclk), .reset(reset), .por_reset(por_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .events(events),
    .cpu_clock_enable(cpu_en), .peripheral_clock_enable(per_en),
    .regulator_low_power(reg_lp), .watchdog_reset_block(wdt_blk));
  disc_core_model core (.mclk(mclk), .reset(reset), .fire(fire), .cpu_clock_enable(cpu_en),
    .events(events), .cpu_cycles(cpu_cycles));

  // A 40 ns clock; the cycle ceiling stops a hung run well past the planned length.
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cycle_count++;
    if (cycle_count > 10000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string w);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, w, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string w);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %b expected %b", $time, w, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen at an edge.
  // Only the bench timeout ends a wait, so no cycle count is assumed here.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares the whole word, upper bits included.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    check_word(q, exp, "register read");
  endtask

  // The model pulses one cycle later; three more edges let the block see it and settle.
  task automatic pulse(input disc_events_s x);
    @(posedge mclk);
    fire <= x;
    @(posedge mclk);
    fire <= '0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic cpu_count(input int n);
    logic [15:0] c0;
    @(posedge mclk);
    c0 = cpu_cycles;
    repeat (n) @(posedge mclk);
    k = cpu_cycles - c0;
  endtask

  task automatic do_reset(input logic por);
    @(posedge mclk);
    reset <= 1'b1;
    por_reset <= por;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    por_reset <= 1'b0;
  endtask

  task automatic test_registers();
    rd(DISC_OFF_REGULATOR, 32'h01);
    rd(DISC_OFF_THROTTLE, 32'h00);
    apb(1'b1, DISC_OFF_REGULATOR, 8'hff);
    rd(DISC_OFF_REGULATOR, 32'h03);
    apb(1'b1, DISC_OFF_REGULATOR, 8'h00);
    rd(DISC_OFF_REGULATOR, 32'h01);
    pstrb <= 4'h0;
    apb(1'b1, DISC_OFF_REGULATOR, 8'h02);
    pstrb <= 4'hf;
    rd(DISC_OFF_REGULATOR, 32'h01);
    apb(1'b1, DISC_OFF_THROTTLE, 8'hff);
    rd(DISC_OFF_THROTTLE, 32'hf7);
    apb(1'b1, 8'h0c, 8'hff);
    check_bit(e, 1'b1, "unmapped write error");
    rd(8'h0c, 32'h00);
    check_bit(e, 1'b1, "unmapped read error");
    $display("test registers done");
  endtask

  task automatic test_ratio();
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, DISC_OFF_THROTTLE, 8'h40 | 8'(r));
      cpu_count(4 << (r + 1));
      check_word({16'h0, k}, 32'h4, "cpu cycles at ratio");
    end
    apb(1'b1, DISC_OFF_THROTTLE, 8'h07);
    cpu_count(16);
    check_word({16'h0, k}, 32'h10, "cpu cycles full speed");
    $display("test ratio done");
  endtask

  task automatic test_isr_return();
    apb(1'b1, DISC_OFF_THROTTLE, 8'h63);
    pulse(EV_ISR);
    rd(DISC_OFF_THROTTLE, 32'h23);
    apb(1'b1, DISC_OFF_THROTTLE, 8'h13);
    pulse(EV_RET);
    rd(DISC_OFF_THROTTLE, 32'h53);
    pulse(EV_ISR);
    rd(DISC_OFF_THROTTLE, 32'h53);
    apb(1'b1, DISC_OFF_THROTTLE, 8'h03);
    pulse(EV_RET);
    rd(DISC_OFF_THROTTLE, 32'h03);
    $display("test interrupt entry and return done");
  endtask

  task automatic test_idle_sleep();
    apb(1'b1, DISC_OFF_THROTTLE, 8'he0);
    pulse(EV_SLEEP);
    check_bit(cpu_en, 1'b0, "cpu stopped in idle");
    check_bit(per_en, 1'b1, "peripherals run in idle");
    check_bit(wdt_blk, 1'b1, "watchdog reset blocked");
    rd(DISC_OFF_STATUS, 32'h01);
    pulse(EV_WDT);
    rd(DISC_OFF_STATUS, 32'h00);
    rd(DISC_OFF_THROTTLE, 32'he0);
    pulse(EV_SLEEP);
    pulse(EV_WAKE);
    rd(DISC_OFF_STATUS, 32'h00);
    rd(DISC_OFF_THROTTLE, 32'he0);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, DISC_OFF_THROTTLE, 8'h00);
      apb(1'b1, DISC_OFF_REGULATOR, m ? 8'h01 : 8'h03);
      pulse(EV_SLEEP);
      check_bit(per_en, 1'b0, "peripherals stop in sleep");
      check_bit(reg_lp, m ? 1'b0 : 1'b1, "regulator mode");
      check_bit(wdt_blk, 1'b0, "no block outside idle");
      pulse(EV_WAKE);
      check_bit(per_en, 1'b1, "peripherals after wake");
    end
    $display("test idle and sleep done");
  endtask

  task automatic test_debug_and_reset();
    apb(1'b1, DISC_OFF_THROTTLE, 8'h47);
    pulse(EV_DBG);
    cpu_count(16);
    check_word({16'h0, k}, 32'h10, "cpu cycles in debug");
    rd(DISC_OFF_THROTTLE, 32'h47);
    rd(DISC_OFF_STATUS, 32'h04);
    apb(1'b1, DISC_OFF_THROTTLE, 8'hc5);
    apb(1'b1, DISC_OFF_REGULATOR, 8'h03);
    do_reset(1'b0);
    rd(DISC_OFF_THROTTLE, 32'h80);
    rd(DISC_OFF_REGULATOR, 32'h01);
    do_reset(1'b1);
    rd(DISC_OFF_THROTTLE, 32'h00);
    $display("test debug and reset done");
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Power-on reset first, then every scenario in turn.
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    por_reset <= 1'b0;
    test_registers();
    test_ratio();
    test_isr_return();
    test_idle_sleep();
    test_debug_and_reset();
    tally_and_finish();
  end
endmodule // disc_power_control_test
`default_nettype wire
